// ### src/pwmcap_pkg.sv
package pwmcap_pkg;

  localparam int          BUS_ADDR_W       = 8;
  localparam int          BUS_DATA_W       = 32;

  // Single registers
  localparam logic [7:0]  ADDR_PRESCALE    = 8'h00;
  localparam logic [7:0]  ADDR_CLKDIV      = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h08;
  localparam logic [7:0]  ADDR_DEADTIME    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_IND     = 8'hE0;
  localparam logic [7:0]  ADDR_IRQ_EN      = 8'hE4;

  // Arrays of eight words (capture control four), region picked by address bits 7:5
  localparam logic [2:0]  REGION_PERIOD    = 3'h1;
  localparam logic [2:0]  REGION_COMPARE   = 3'h2;
  localparam logic [2:0]  REGION_COUNT     = 3'h3;
  localparam logic [2:0]  REGION_CAPCTL    = 3'h4;
  localparam logic [2:0]  REGION_RISE      = 3'h5;
  localparam logic [2:0]  REGION_FALL      = 3'h6;

  // Control register fields
  localparam int          CTL_RUN_LSB      = 0;
  localparam int          CTL_RELOAD_LSB   = 8;
  localparam int          CTL_DZ_LSB       = 16;

  // Capture control fields, channel pair per word
  localparam int          CAP_EN_BIT       = 0;
  localparam int          CAP_RISE_IE_BIT  = 1;
  localparam int          CAP_FALL_IE_BIT  = 2;
  localparam int          CAP_CH1_OFS      = 16;

  // Indicator / enable layout
  localparam int          IND_PERIOD_LSB   = 0;
  localparam int          IND_CAP_LSB      = 8;

  // Clock divider field: one nibble per generator
  localparam int          DIV_FIELD_W      = 4;
  localparam logic [3:0]  DIV_BY_1         = 4'h0;
  localparam logic [3:0]  DIV_BY_2         = 4'h1;
  localparam logic [3:0]  DIV_BY_4         = 4'h2;
  localparam logic [3:0]  DIV_BY_8         = 4'h3;

  localparam logic [31:0] REG_RESET        = 32'h0000_0000;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [BUS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } pwmcap_bus_req_type;

endpackage : pwmcap_pkg

// ### src/pwmcap_top.sv
// Functional notes
// - Each generator: 8-bit prescaler then divide by 1, 2, 4, 8 or 16
// - Two 16-bit down-counters and two comparators per generator
// - Eight independent outputs or four complementary pairs with dead zone
// - Pair enable: pair uses even timer and its dead-zone generator
// - Period and compare writes buffered, loaded when counter hits zero
// - Eight period flags set at zero, interrupt only when enabled
// - Auto-reload: reload from period value at zero, keep counting
// - One-shot: stop at zero after one flag, one cycle only
// - Output goes high when counter equals compare value
// - Capture enable turns pin into input sharing timer n
// - Rising edge latches counter to rise latch, falling to fall latch
// - Separate rise and fall interrupt enables per capture channel
// - Per channel rise latch, fall latch, flag set on enabled edge
// - Capture interrupt on channel n reloads counter n
// - Indicator bits cleared only by writing one
//
// The address map and the address-and-strobe port were decided locally.
module pwmcap_top #(
  parameter int CNT_WIDTH = 16
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  input  wire pwmcap_pkg::pwmcap_bus_req_type bus_req_in,
  output logic [pwmcap_pkg::BUS_DATA_W-1:0] bus_rdata_out,
  input  wire logic [7:0]                  pwm_pin_in,
  output logic [7:0]                       pwm_out,
  output logic [7:0]                       pwm_oe_out,
  output logic                             irq_out
);
  import pwmcap_pkg::*;

  localparam int NUM_CH  = 8;
  localparam int NUM_GEN = 4;

  if (CNT_WIDTH < 1 || CNT_WIDTH > 16) begin : g_bad_width
    $error("CNT_WIDTH must lie in 1..16");
  end

  typedef logic [CNT_WIDTH-1:0] pwmcap_cnt_type;

  // Register file
  logic [31:0]    prescale_r;
  logic [31:0]    clkdiv_r;
  logic [31:0]    pwm_control_reg_r;
  logic [31:0]    deadtime_r;
  pwmcap_cnt_type period_reload_value_r [NUM_CH];
  pwmcap_cnt_type compare_buf_r         [NUM_CH];
  logic [31:0]    capture_ctl_r         [NUM_GEN];
  pwmcap_cnt_type rise_capture_latch_r  [NUM_CH];
  pwmcap_cnt_type fall_capture_latch_r  [NUM_CH];
  logic [15:0]    pwm_irq_indicator_r;
  logic [15:0]    irq_enable_r;
  logic [31:0]    bus_rdata_r;

  // Timer state
  logic [7:0]     pre_cnt_r   [NUM_GEN];
  logic [3:0]     div_cnt_r   [NUM_GEN];
  logic [NUM_GEN-1:0] gen_tick;
  pwmcap_cnt_type count_r     [NUM_CH];
  pwmcap_cnt_type period_act_r[NUM_CH];
  pwmcap_cnt_type compare_act_r[NUM_CH];
  logic [NUM_CH-1:0] stopped_r;
  logic [NUM_CH-1:0] raw_out_r;
  logic [NUM_CH-1:0] run_prev_r;
  logic [NUM_CH-1:0] zero_evt;

  // Capture state
  logic [NUM_CH-1:0] sync1_r;
  logic [NUM_CH-1:0] sync2_r;
  logic [NUM_CH-1:0] sync3_r;
  logic [NUM_CH-1:0] cap_level_r;
  logic [NUM_CH-1:0] cap_rise;
  logic [NUM_CH-1:0] cap_fall;
  logic [NUM_CH-1:0] cap_evt;

  // Dead zone
  logic [3:0]     dz_src_prev_r;
  logic [7:0]     dz_cnt_r [4];
  logic [NUM_CH-1:0] pin_out_r;

  logic [2:0]     region;
  logic [2:0]     index;
  logic [15:0]    ind_set;
  logic [15:0]    ind_clr;

  assign region = bus_req_in.addr[7:5];
  assign index  = bus_req_in.addr[4:2];

  function automatic logic [3:0] div_limit(input logic [3:0] code);
    // Codes above divide-by-8 all give divide-by-16, the slowest rate
    unique case (code)
      DIV_BY_1: div_limit = 4'h0;
      DIV_BY_2: div_limit = 4'h1;
      DIV_BY_4: div_limit = 4'h3;
      DIV_BY_8: div_limit = 4'h7;
      default:  div_limit = 4'hF;
    endcase
  endfunction : div_limit

  function automatic logic cap_bit(input logic [31:0] ctl [NUM_GEN],
                                   input int ch, input int bit_pos);
    cap_bit = ctl[ch/2][(ch%2)*CAP_CH1_OFS + bit_pos];
  endfunction : cap_bit

  function automatic logic arr_wr(input pwmcap_bus_req_type req,
                                  input logic [2:0] reg_region,
                                  input int idx);
    arr_wr = req.wr && req.addr[7:5] == reg_region &&
             req.addr[4:2] == idx[2:0];
  endfunction : arr_wr

  // Configuration registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_r        <= REG_RESET;
      clkdiv_r          <= REG_RESET;
      pwm_control_reg_r <= REG_RESET;
      deadtime_r        <= REG_RESET;
      irq_enable_r      <= REG_RESET[15:0];
    end else if (bus_req_in.wr) begin
      unique case (bus_req_in.addr)
        ADDR_PRESCALE: prescale_r        <= bus_req_in.wdata;
        ADDR_CLKDIV:   clkdiv_r          <= bus_req_in.wdata;
        ADDR_CONTROL:  pwm_control_reg_r <= bus_req_in.wdata;
        ADDR_DEADTIME: deadtime_r        <= bus_req_in.wdata;
        ADDR_IRQ_EN:   irq_enable_r      <= bus_req_in.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Buffered period/compare and capture control
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        period_reload_value_r[c] <= '0;
        compare_buf_r[c]         <= '0;
      end
      for (int k = 0; k < NUM_GEN; k++) begin
        capture_ctl_r[k] <= REG_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (arr_wr(bus_req_in, REGION_PERIOD, c)) begin
          period_reload_value_r[c] <= bus_req_in.wdata[CNT_WIDTH-1:0];
        end
        if (arr_wr(bus_req_in, REGION_COMPARE, c)) begin
          compare_buf_r[c] <= bus_req_in.wdata[CNT_WIDTH-1:0];
        end
      end
      for (int k = 0; k < NUM_GEN; k++) begin
        if (arr_wr(bus_req_in, REGION_CAPCTL, k)) begin
          capture_ctl_r[k] <= bus_req_in.wdata;
        end
      end
    end
  end

  // Prescaler and divider per generator
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        pre_cnt_r[g] <= 8'h00;
        div_cnt_r[g] <= 4'h0;
      end
    end else begin
      for (int g = 0; g < NUM_GEN; g++) begin
        if (pre_cnt_r[g] == prescale_r[g*8 +: 8]) begin
          pre_cnt_r[g] <= 8'h00;
          if (div_cnt_r[g] >=
              div_limit(clkdiv_r[g*DIV_FIELD_W +: DIV_FIELD_W])) begin
            div_cnt_r[g] <= 4'h0;
          end else begin
            div_cnt_r[g] <= div_cnt_r[g] + 4'h1;
          end
        end else begin
          pre_cnt_r[g] <= pre_cnt_r[g] + 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int g = 0; g < NUM_GEN; g++) begin
      gen_tick[g] = (pre_cnt_r[g] == prescale_r[g*8 +: 8]) &&
                    (div_cnt_r[g] >=
                     div_limit(clkdiv_r[g*DIV_FIELD_W +: DIV_FIELD_W]));
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      zero_evt[c] = pwm_control_reg_r[CTL_RUN_LSB + c] && run_prev_r[c] &&
                    !stopped_r[c] && gen_tick[c/2] &&
                    count_r[c] == '0;
    end
  end

  // Down-counters, one per channel, two per generator
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        count_r[c]       <= '0;
        period_act_r[c]  <= '0;
        compare_act_r[c] <= '0;
      end
      stopped_r  <= '0;
      raw_out_r  <= '0;
      run_prev_r <= '0;
    end else begin
      run_prev_r <= pwm_control_reg_r[CTL_RUN_LSB +: NUM_CH];
      for (int c = 0; c < NUM_CH; c++) begin
        if (!pwm_control_reg_r[CTL_RUN_LSB + c]) begin
          stopped_r[c] <= 1'b0;
          raw_out_r[c] <= 1'b0;
        end else if (!run_prev_r[c]) begin
          // Start of run takes the buffers at once
          count_r[c]       <= period_reload_value_r[c];
          period_act_r[c]  <= period_reload_value_r[c];
          compare_act_r[c] <= compare_buf_r[c];
          raw_out_r[c]     <= 1'b0;
        end else if (cap_evt[c]) begin
          count_r[c] <= period_act_r[c];
        end else if (zero_evt[c]) begin
          period_act_r[c]  <= period_reload_value_r[c];
          compare_act_r[c] <= compare_buf_r[c];
          if (pwm_control_reg_r[CTL_RELOAD_LSB + c]) begin
            count_r[c]   <= period_reload_value_r[c];
            raw_out_r[c] <= 1'b0;
          end else begin
            stopped_r[c] <= 1'b1;
          end
        end else if (gen_tick[c/2] && !stopped_r[c]) begin
          count_r[c] <= count_r[c] - 1'b1;
          if (count_r[c] == compare_act_r[c]) begin
            raw_out_r[c] <= 1'b1;
          end
        end
      end
    end
  end

  // Capture inputs, three stages; second and third must agree
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      sync3_r     <= '0;
      cap_level_r <= '0;
    end else begin
      sync1_r <= pwm_pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int c = 0; c < NUM_CH; c++) begin
        if (sync2_r[c] == sync3_r[c]) begin
          cap_level_r[c] <= sync3_r[c];
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      cap_rise[c] = cap_bit(capture_ctl_r, c, CAP_EN_BIT) &&
                    sync2_r[c] == sync3_r[c] &&
                    sync3_r[c] && !cap_level_r[c];
      cap_fall[c] = cap_bit(capture_ctl_r, c, CAP_EN_BIT) &&
                    sync2_r[c] == sync3_r[c] &&
                    !sync3_r[c] && cap_level_r[c];
      cap_evt[c]  = (cap_rise[c] &&
                     cap_bit(capture_ctl_r, c, CAP_RISE_IE_BIT)) ||
                    (cap_fall[c] &&
                     cap_bit(capture_ctl_r, c, CAP_FALL_IE_BIT));
    end
  end

  // Latches count whether or not the edge interrupt is enabled
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rise_capture_latch_r[c] <= '0;
        fall_capture_latch_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cap_rise[c]) begin
          rise_capture_latch_r[c] <= count_r[c];
        end
        if (cap_fall[c]) begin
          fall_capture_latch_r[c] <= count_r[c];
        end
      end
    end
  end

  // Interrupt indicator: set beats a same-cycle clear
  always_comb begin
    ind_set = {cap_evt, zero_evt};
    ind_clr = (bus_req_in.wr && bus_req_in.addr == ADDR_IRQ_IND) ?
              bus_req_in.wdata[15:0] : 16'h0000;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_irq_indicator_r <= REG_RESET[15:0];
    end else begin
      pwm_irq_indicator_r <= (pwm_irq_indicator_r & ~ind_clr) | ind_set;
    end
  end

  assign irq_out = |(pwm_irq_indicator_r & irq_enable_r);

  // Dead-zone generators on even channels
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dz_src_prev_r <= '0;
      for (int p = 0; p < 4; p++) begin
        dz_cnt_r[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        dz_src_prev_r[p] <= raw_out_r[2*p];
        if (raw_out_r[2*p] != dz_src_prev_r[p]) begin
          dz_cnt_r[p] <= deadtime_r[p*8 +: 8];
        end else if (dz_cnt_r[p] != 8'h00) begin
          dz_cnt_r[p] <= dz_cnt_r[p] - 8'h01;
        end
      end
    end
  end

  // Output stage; both pair outputs held low through the dead time
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out_r <= '0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (pwm_control_reg_r[CTL_DZ_LSB + p]) begin
          if (raw_out_r[2*p] != dz_src_prev_r[p] || dz_cnt_r[p] > 8'h01) begin
            pin_out_r[2*p]   <= 1'b0;
            pin_out_r[2*p+1] <= 1'b0;
          end else begin
            pin_out_r[2*p]   <= raw_out_r[2*p];
            pin_out_r[2*p+1] <= !raw_out_r[2*p];
          end
        end else begin
          pin_out_r[2*p]   <= raw_out_r[2*p];
          pin_out_r[2*p+1] <= raw_out_r[2*p+1];
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pwm_out[c]    = pin_out_r[c];
      pwm_oe_out[c] = pwm_control_reg_r[CTL_RUN_LSB + c] &&
                      !cap_bit(capture_ctl_r, c, CAP_EN_BIT);
    end
  end

  // Read port, data in the cycle after the strobe only
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_r <= REG_RESET;
    end else if (bus_req_in.rd) begin
      bus_rdata_r <= 32'h0000_0000;
      unique case (region)
        REGION_PERIOD:  bus_rdata_r[CNT_WIDTH-1:0] <=
                          period_reload_value_r[index];
        REGION_COMPARE: bus_rdata_r[CNT_WIDTH-1:0] <= compare_buf_r[index];
        REGION_COUNT:   bus_rdata_r[CNT_WIDTH-1:0] <= count_r[index];
        REGION_CAPCTL:  if (index < 3'd4) begin
                          bus_rdata_r <= capture_ctl_r[index[1:0]];
                        end
        REGION_RISE:    bus_rdata_r[CNT_WIDTH-1:0] <=
                          rise_capture_latch_r[index];
        REGION_FALL:    bus_rdata_r[CNT_WIDTH-1:0] <=
                          fall_capture_latch_r[index];
        default: begin
          unique case (bus_req_in.addr)
            ADDR_PRESCALE: bus_rdata_r <= prescale_r;
            ADDR_CLKDIV:   bus_rdata_r <= clkdiv_r;
            ADDR_CONTROL:  bus_rdata_r <= pwm_control_reg_r;
            ADDR_DEADTIME: bus_rdata_r <= deadtime_r;
            ADDR_IRQ_IND:  bus_rdata_r[15:0] <= pwm_irq_indicator_r;
            ADDR_IRQ_EN:   bus_rdata_r[15:0] <= irq_enable_r;
            default: ;
          endcase
        end
      endcase
    end else begin
      bus_rdata_r <= REG_RESET;
    end
  end

  assign bus_rdata_out = bus_rdata_r;

endmodule : pwmcap_top

// ### tb/pwmcap_checker.sv
module pwmcap_checker
  import pwmcap_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_n_in,
  input  wire pwmcap_pkg::pwmcap_bus_req_type bus_req_in,
  input  wire logic [pwmcap_pkg::BUS_DATA_W-1:0] bus_rdata_out,
  input  wire logic [7:0]                    pwm_pin_in,
  input  wire logic [7:0]                    pwm_out,
  input  wire logic [7:0]                    pwm_oe_out,
  input  wire logic                          irq_out
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [31:0] ctl_r;
  logic [31:0] cap_r;
  logic [7:0]  dt_r;
  logic        pair_on;

  // Shadow of software writes, taken on the same edge as the design
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r <= REG_RESET;
      cap_r <= REG_RESET;
      dt_r  <= 8'h00;
    end else if (bus_req_in.wr) begin
      if (bus_req_in.addr == ADDR_CONTROL) ctl_r <= bus_req_in.wdata;
      if (bus_req_in.addr == 8'h80) cap_r <= bus_req_in.wdata;
      if (bus_req_in.addr == ADDR_DEADTIME) dt_r <= bus_req_in.wdata[7:0];
    end
  end

  // Gap checks need at least two dead cycles to be meaningful
  assign pair_on = ctl_r[CTL_DZ_LSB] && (dt_r >= 8'h02);

  property p_irq_mask;
    bus_req_in.wr && bus_req_in.addr == ADDR_IRQ_EN &&
      bus_req_in.wdata == REG_RESET |=> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq high with all enables cleared");

  property p_rd_idle;
    !$past(bus_req_in.rd) |-> bus_rdata_out == REG_RESET;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");

  property p_cap_oe;
    cap_r[CAP_CH1_OFS + CAP_EN_BIT] |-> !pwm_oe_out[1];
  endproperty
  a_cap_oe: assert property (p_cap_oe)
    else $error("capture channel still drives its pin");

  property p_run_oe;
    !ctl_r[CTL_RUN_LSB] |-> !pwm_oe_out[0];
  endproperty
  a_run_oe: assert property (p_run_oe)
    else $error("stopped channel drives its pin");

  property p_start_low;
    $rose(ctl_r[CTL_RUN_LSB]) |=> !pwm_out[0];
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("output not low at period start");

  property p_pair_excl;
    pair_on && $past(pair_on, 3) |-> !(pwm_out[0] && pwm_out[1]);
  endproperty
  a_pair_excl: assert property (p_pair_excl)
    else $error("both pair outputs high");

  property p_fall_gap;
    pair_on && $past(pair_on, 3) && $fell(pwm_out[0]) |->
      !pwm_out[1] [*2];
  endproperty
  a_fall_gap: assert property (p_fall_gap)
    else $error("odd output rose without dead time");

  property p_rise_gap;
    pair_on && $past(pair_on, 3) && $rose(pwm_out[0]) |->
      !$past(pwm_out[1]) && !$past(pwm_out[1], 2);
  endproperty
  a_rise_gap: assert property (p_rise_gap)
    else $error("even output rose without dead time");
endmodule : pwmcap_checker

bind pwmcap_top pwmcap_checker #(.CNT_WIDTH(CNT_WIDTH)) u_checker (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
  .bus_rdata_out(bus_rdata_out), .pwm_pin_in(pwm_pin_in),
  .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out), .irq_out(irq_out));

// ### tb/pwmcap_pin_model.sv
module pwmcap_pin_model (
  input  wire logic [7:0] pwm_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] src_en_in,
  input  wire logic [7:0] src_lvl_in,
  output logic      [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Undriven pins float up through the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) pin_out[i] = pwm_in[i];
      else if (src_en_in[i]) pin_out[i] = src_lvl_in[i];
      else pin_out[i] = 1'b1;
    end
  end
endmodule : pwmcap_pin_model

// ### tb/pwm_generator_capture_timer_tb_top.sv
module pwm_generator_capture_timer_tb_top import pwmcap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic               ref_clk_in;
  logic               rst_n_in;
  pwmcap_bus_req_type req;
  logic [31:0]        rdata;
  logic [7:0]         pin;
  logic [7:0]         pwm;
  logic [7:0]         oe;
  logic [7:0]         src_lvl;
  logic               irq;
  int                 bad_count;
  int                 checked;

  pwmcap_top #(.CNT_WIDTH(16)) dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_req_in(req),
    .bus_rdata_out(rdata), .pwm_pin_in(pin), .pwm_out(pwm),
    .pwm_oe_out(oe), .irq_out(irq));

  pwmcap_pin_model u_pins (
    .pwm_in(pwm), .oe_in(oe), .src_en_in(8'h02), .src_lvl_in(src_lvl),
    .pin_out(pin));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cycles

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: REG_RESET, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdc

  task automatic wait_lvl(input int ch, input logic v);
    int n;
    n = 0;
    while (pwm[ch] !== v) begin
      @(posedge ref_clk_in);
      n++;
      if (n > 600) begin
        bad_count++;
        $display("[ERR] %0t output wait timed out", $time);
        tally_and_finish();
      end
    end
  endtask : wait_lvl

  task automatic s_regs;
    rdc(ADDR_CONTROL, REG_RESET);
    rdc(ADDR_IRQ_IND, REG_RESET);
    wr(8'h60, 32'h0000_1234);
    rdc(8'h60, REG_RESET);
    rdc(8'hF0, REG_RESET);
    wr(ADDR_PRESCALE, 32'h0000_00A5);
    rdc(ADDR_PRESCALE, 32'h0000_00A5);
  endtask : s_regs

  task automatic s_divider;
    time t0;
    wr(8'h20, 32'h0000_0003);
    wr(8'h40, 32'h0000_0001);
    wr(ADDR_PRESCALE, 32'h0000_0001);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CONTROL, REG_RESET);
      wr(ADDR_CLKDIV, 32'(k));
      wr(ADDR_CONTROL, 32'h0000_0101);
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      t0 = $time;
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      chk(32'(($time - t0) / 20), 32'(8 << k));
    end
  endtask : s_divider

  task automatic s_duty;
    int c;
    wr(ADDR_CONTROL, REG_RESET);
    wr(ADDR_PRESCALE, REG_RESET);
    wr(ADDR_CLKDIV, REG_RESET);
    wr(8'h40, 32'h0000_0002);
    wr(ADDR_CONTROL, 32'h0000_0101);
    for (int p = 0; p < 2; p++) begin
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      c = 0;
      repeat (40) begin
        @(posedge ref_clk_in);
        if (pwm[0] === 1'b1) c++;
      end
      chk(32'(c), 32'(20 - 10 * p));
      // New compare waits in the buffer until the next zero
      wr(8'h40, 32'h0000_0001);
    end
  endtask : s_duty

  task automatic s_oneshot;
    wr(ADDR_CONTROL, REG_RESET);
    wr(8'h28, 32'h0000_0005);
    wr(8'h48, 32'h0000_0002);
    wr(ADDR_IRQ_IND, 32'h0000_00FF);
    wr(ADDR_IRQ_EN, 32'h0000_0004);
    wr(ADDR_CONTROL, 32'h0000_0004);
    cycles(30);
    rdc(8'h68, REG_RESET);
    rdc(ADDR_IRQ_IND, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_IRQ_IND, REG_RESET);
    rdc(ADDR_IRQ_IND, 32'h0000_0004);
    wr(ADDR_IRQ_EN, REG_RESET);
    cycles(2);
    chk(32'(irq), REG_RESET);
    wr(ADDR_IRQ_IND, 32'h0000_0004);
    rdc(ADDR_IRQ_IND, REG_RESET);
    cycles(30);
    rdc(ADDR_IRQ_IND, REG_RESET);
  endtask : s_oneshot

  task automatic s_capture;
    logic [31:0] d;
    wr(ADDR_CONTROL, REG_RESET);
    wr(8'h24, 32'h0000_0FFF);
    wr(ADDR_IRQ_EN, 32'h0000_0200);
    // Timer first: the capture latches the count as it stands, running or not
    wr(ADDR_CONTROL, 32'h0000_0202);
    cycles(400);
    wr(8'h80, 32'h0003_0000);
    cycles(1);
    chk(32'(oe[1]), REG_RESET);
    src_lvl <= 8'h02;
    cycles(8);
    rd(8'h64, d);
    chk(32'(d > 32'h0000_0FE0), 32'h0000_0001);
    rd(8'hA4, d);
    chk(32'(d < 32'h0000_0F00 && d != 0), 32'h0000_0001);
    rdc(ADDR_IRQ_IND, 32'h0000_0200);
    chk(32'(irq), 32'h0000_0001);
    wr(ADDR_IRQ_IND, 32'h0000_0200);
    src_lvl <= 8'h00;
    cycles(8);
    rdc(ADDR_IRQ_IND, REG_RESET);
    rd(8'hC4, d);
    chk(32'(d > 32'h0000_0F00 && d < 32'h0000_1000), 32'h1);
    // Swap to falling-edge interrupt only
    wr(8'h80, 32'h0005_0000);
    rdc(8'h80, 32'h0005_0000);
    src_lvl <= 8'h02;
    cycles(8);
    rdc(ADDR_IRQ_IND, REG_RESET);
    src_lvl <= 8'h00;
    cycles(8);
    rdc(ADDR_IRQ_IND, 32'h0000_0200);
    rd(8'h64, d);
    chk(32'(d > 32'h0000_0FE0), 32'h0000_0001);
    wr(ADDR_IRQ_IND, 32'h0000_0200);
  endtask : s_capture

  task automatic s_pair;
    int n0;
    int n1;
    int nb;
    wr(ADDR_CONTROL, REG_RESET);
    wr(8'h80, REG_RESET);
    wr(ADDR_DEADTIME, 32'h0000_0003);
    wr(8'h20, 32'h0000_0007);
    wr(8'h40, 32'h0000_0004);
    wr(ADDR_CONTROL, 32'h0001_0303);
    cycles(1);
    chk(32'(oe[1:0]), 32'h0000_0003);
    cycles(20);
    n0 = 0;
    n1 = 0;
    nb = 0;
    repeat (80) begin
      @(posedge ref_clk_in);
      if (pwm[0] === 1'b1) n0++;
      if (pwm[1] === 1'b1) n1++;
      if (pwm[0] === 1'b1 && pwm[1] === 1'b1) nb++;
    end
    chk(32'(n0), 32'h0000_000A);
    chk(32'(n1), 32'h0000_000A);
    chk(32'(nb), REG_RESET);
  endtask : s_pair

  initial begin
    rst_n_in = 1'b0;
    req = '0;
    src_lvl = 8'h00;
    bad_count = 0;
    checked = 0;
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    s_regs();
    s_divider();
    s_duty();
    s_oneshot();
    s_capture();
    s_pair();
    tally_and_finish();
  end
endmodule : pwm_generator_capture_timer_tb_top
